// ==== dsp_pkg.sv ====
// Constants, register map and Gray-code helpers for the strobe phase block.
// Assumes a single 40 MHz register clock and a 32-bit APB slave.
package dsp_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_GROUPS = 4;
    localparam int TAP_W = 3;
    localparam int SET_W = 6;
    localparam int OFF_W = 7;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OFF_TB = 8'h04;
    localparam logic [7:0] ADDR_OFF_LR = 8'h08;
    localparam logic [7:0] ADDR_WL_TAPS = 8'h0C;
    localparam logic [7:0] ADDR_RS_TAPS = 8'h10;
    localparam logic [7:0] ADDR_PA_TAPS = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_CHAIN = 8'h1C;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_CNT_LSB = 3;
    localparam int CTL_BYPASS = 5;
    localparam int CTL_USE_OFF = 6;
    localparam int CTL_SIDE_LR = 7;
    localparam int CTL_USE_DLL = 8;
    localparam int CTL_DYN_OFF = 9;
    localparam int CTL_UPD_USER = 10;
    localparam int CTL_HALF_RATE = 11;
    localparam int CTL_W = 12;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [CTL_W-1:0] CTRL_RST = 12'h118;
    localparam logic [OFF_W-1:0] OFF_RST = 7'h00;
    localparam logic [11:0] TAPS_RST = 12'h000;

    // ----------------------------------------
    // Modes, limits and timing counts
    // ----------------------------------------
    localparam logic [2:0] MODE_HI_FIRST = 3'h4;
    localparam logic [OFF_W-1:0] CEIL_LO = 7'h40;
    localparam logic [OFF_W-1:0] CEIL_HI = 7'h20;
    localparam logic signed [8:0] OFF_MAX_LO = 9'sh03F;
    localparam logic signed [8:0] OFF_MIN_LO = -9'sh040;
    localparam logic signed [8:0] OFF_MAX_HI = 9'sh01F;
    localparam logic signed [8:0] OFF_MIN_HI = -9'sh020;
    localparam logic [3:0] UPD_TICKS = 4'h8;
    localparam logic [TAP_W-1:0] TAP_90 = 3'h2;

    function automatic logic [OFF_W-1:0] gray2bin(input logic [OFF_W-1:0] g);
        logic [OFF_W-1:0] b;
        b[OFF_W-1] = g[OFF_W-1];
        for (int i = OFF_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    function automatic logic [OFF_W-1:0] bin2gray(input logic [OFF_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    // Tap k of the eight-step chain is high for half of each period, 45 deg per step
    function automatic logic tap_hi(input logic [TAP_W-1:0] ph, input logic [TAP_W-1:0] tap);
        logic [TAP_W-1:0] d;
        d = ph - tap;
        return ~d[TAP_W-1];
    endfunction : tap_hi

endpackage : dsp_pkg

// ==== dsp_offset_adj.sv ====
// One phase-offset module: adds a signed offset to the DLL delay setting.
// Assumes dll_gray is Gray coded and already masked for the frequency mode.
`timescale 1ns/1ps
`default_nettype none
module dsp_offset_adj (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mode_hi,
    input wire logic [dsp_pkg::SET_W-1:0] dll_gray,
    input wire logic signed [dsp_pkg::OFF_W-1:0] off_bin,
    output logic [dsp_pkg::OFF_W-1:0] adj_gray_q,
    output logic sign_q
);
    logic [dsp_pkg::OFF_W-1:0] dll_bin;
    logic signed [8:0] off_clip;
    logic signed [8:0] sum;
    logic [dsp_pkg::OFF_W-1:0] ceil;
    logic [dsp_pkg::OFF_W-1:0] adj_bin;

    always_comb begin
        dll_bin = dsp_pkg::gray2bin({1'b0, dll_gray});
        ceil = mode_hi ? dsp_pkg::CEIL_HI : dsp_pkg::CEIL_LO;
        off_clip = 9'(off_bin);
        if (mode_hi && off_clip > dsp_pkg::OFF_MAX_HI) begin
            off_clip = dsp_pkg::OFF_MAX_HI;
        end else if (mode_hi && off_clip < dsp_pkg::OFF_MIN_HI) begin
            off_clip = dsp_pkg::OFF_MIN_HI;
        end
        sum = $signed({2'b00, dll_bin}) + off_clip;
        // Saturate rather than wrap so a large offset cannot jump the phase
        if (sum < 0) begin
            adj_bin = '0;
        end else if (sum > $signed({2'b00, ceil})) begin
            adj_bin = ceil;
        end else begin
            adj_bin = sum[dsp_pkg::OFF_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            adj_gray_q <= '0;
            sign_q <= 1'b0;
        end else begin
            adj_gray_q <= dsp_pkg::bin2gray(adj_bin);
            sign_q <= off_bin[dsp_pkg::OFF_W-1];
        end
    end

    a_adj_ceiling: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(mode_hi) |-> dsp_pkg::gray2bin(adj_gray_q) <= dsp_pkg::CEIL_HI)
        else $error("adjusted setting above ceiling");

    a_sign_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 sign_q == $past(off_bin[dsp_pkg::OFF_W-1]))
        else $error("sign bit does not follow offset");

    a_adj_zero_floor: assert property (@(posedge mclk) disable iff (!rst_n)
        (dll_gray == '0 && off_bin[dsp_pkg::OFF_W-1]) |=> adj_gray_q == '0)
        else $error("negative sum not held at zero");

endmodule : dsp_offset_adj
`default_nettype wire

// ==== dsp_strobe_top.sv ====
// Read-strobe phase block: offsets, delay chain settings, postamble gate, leveling.
// Assumes the DLL core, reference and user ticks are synchronous to mclk.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dsp_strobe_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dsp_pkg::SET_W-1:0] dll_gray,
    input wire logic ref_tick,
    input wire logic user_tick,
    input wire logic [dsp_pkg::SET_W-1:0] offset_amt,
    input wire logic offset_addnsub,
    input wire logic [dsp_pkg::SET_W-1:0] user_delay_gray,
    input wire logic strobe_en,
    output logic [dsp_pkg::SET_W-1:0] dll_set_gray,
    output logic [dsp_pkg::OFF_W-1:0] adj_tb_gray,
    output logic [dsp_pkg::OFF_W-1:0] adj_lr_gray,
    output logic sign_tb,
    output logic sign_lr,
    output logic upd_pulse,
    output logic [dsp_pkg::OFF_W-1:0] elem0_set,
    output logic [dsp_pkg::SET_W-1:0] elem_set,
    output logic [3:0] elem_en,
    output logic chain_bypass,
    output logic strobe_gate,
    output logic [dsp_pkg::NUM_GROUPS-1:0] wl_dqs_clk,
    output logic [dsp_pkg::NUM_GROUPS-1:0] wl_dq_clk,
    output logic [dsp_pkg::NUM_GROUPS-1:0] rs_clk,
    output logic [dsp_pkg::NUM_GROUPS-1:0] pa_clk,
    output logic hr_rs_clk
);
    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [dsp_pkg::CTL_W-1:0] ctrl_q;
    logic [dsp_pkg::OFF_W-1:0] off_tb_q;
    logic [dsp_pkg::OFF_W-1:0] off_lr_q;
    logic [11:0] wl_taps_q;
    logic [11:0] rs_taps_q;
    logic [11:0] pa_taps_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rdata_d;
    logic hit;
    logic acc;
    logic wr_go;

    assign acc = psel & penable;
    assign wr_go = acc & pready_q & pwrite & hit;

    always_comb begin
        hit = 1'b1;
        rdata_d = '0;
        case (paddr)
            dsp_pkg::ADDR_CTRL: rdata_d[dsp_pkg::CTL_W-1:0] = ctrl_q;
            dsp_pkg::ADDR_OFF_TB: rdata_d[dsp_pkg::OFF_W-1:0] = off_tb_q;
            dsp_pkg::ADDR_OFF_LR: rdata_d[dsp_pkg::OFF_W-1:0] = off_lr_q;
            dsp_pkg::ADDR_WL_TAPS: rdata_d[11:0] = wl_taps_q;
            dsp_pkg::ADDR_RS_TAPS: rdata_d[11:0] = rs_taps_q;
            dsp_pkg::ADDR_PA_TAPS: rdata_d[11:0] = pa_taps_q;
            dsp_pkg::ADDR_STATUS: rdata_d = {5'h00, strobe_gate, sign_lr, sign_tb,
                1'b0, elem0_set, 1'b0, adj_lr_gray, 1'b0, adj_tb_gray};
            dsp_pkg::ADDR_CHAIN: rdata_d = {15'h0000, chain_bypass, elem_en,
                elem_set, dll_set_gray};
            default: hit = 1'b0;
        endcase
    end

    // One wait state: ready comes from a flop, so every access takes two access cycles
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc & ~pready_q;
            if (acc && !pready_q) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
                pslverr_q <= ~hit;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= dsp_pkg::CTRL_RST;
            off_tb_q <= dsp_pkg::OFF_RST;
            off_lr_q <= dsp_pkg::OFF_RST;
            wl_taps_q <= dsp_pkg::TAPS_RST;
            rs_taps_q <= dsp_pkg::TAPS_RST;
            pa_taps_q <= dsp_pkg::TAPS_RST;
        end else if (wr_go) begin
            case (paddr)
                dsp_pkg::ADDR_CTRL: ctrl_q <= pwdata[dsp_pkg::CTL_W-1:0];
                dsp_pkg::ADDR_OFF_TB: off_tb_q <= pwdata[dsp_pkg::OFF_W-1:0];
                dsp_pkg::ADDR_OFF_LR: off_lr_q <= pwdata[dsp_pkg::OFF_W-1:0];
                dsp_pkg::ADDR_WL_TAPS: wl_taps_q <= pwdata[11:0];
                dsp_pkg::ADDR_RS_TAPS: rs_taps_q <= pwdata[11:0];
                dsp_pkg::ADDR_PA_TAPS: pa_taps_q <= pwdata[11:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------
    // DLL setting and offsets
    // ----------------------------------------
    logic mode_hi;
    logic [dsp_pkg::SET_W-1:0] dll_set_q;
    logic [dsp_pkg::SET_W-1:0] src_gray;
    logic [dsp_pkg::OFF_W-1:0] dyn_mag;
    logic signed [dsp_pkg::OFF_W-1:0] dyn_off;
    logic signed [dsp_pkg::OFF_W-1:0] tb_off;
    logic signed [dsp_pkg::OFF_W-1:0] lr_off;

    assign mode_hi = ctrl_q[dsp_pkg::CTL_MODE_LSB +: 3] >= dsp_pkg::MODE_HI_FIRST;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dll_set_q <= '0;
        end else begin
            // Gray code of a value below 32 already has a zero top bit
            dll_set_q <= mode_hi ? {1'b0, dll_gray[4:0]} : dll_gray;
        end
    end
    assign dll_set_gray = dll_set_q;

    always_comb begin
        dyn_mag = dsp_pkg::gray2bin({1'b0, offset_amt});
        dyn_off = offset_addnsub ? $signed(dyn_mag) : -$signed(dyn_mag);
        tb_off = ctrl_q[dsp_pkg::CTL_DYN_OFF] ? dyn_off : $signed(dsp_pkg::gray2bin(off_tb_q));
        lr_off = ctrl_q[dsp_pkg::CTL_DYN_OFF] ? dyn_off : $signed(dsp_pkg::gray2bin(off_lr_q));
        if (ctrl_q[dsp_pkg::CTL_USE_DLL]) begin
            src_gray = dll_set_q;
        end else begin
            src_gray = mode_hi ? {1'b0, user_delay_gray[4:0]} : user_delay_gray;
        end
    end

    // Two independent offset modules per DLL
    dsp_offset_adj u_off_tb (
        .mclk(mclk),
        .rst_n(rst_n),
        .mode_hi(mode_hi),
        .dll_gray(dll_set_q),
        .off_bin(tb_off),
        .adj_gray_q(adj_tb_gray),
        .sign_q(sign_tb)
    );

    dsp_offset_adj u_off_lr (
        .mclk(mclk),
        .rst_n(rst_n),
        .mode_hi(mode_hi),
        .dll_gray(dll_set_q),
        .off_bin(lr_off),
        .adj_gray_q(adj_lr_gray),
        .sign_q(sign_lr)
    );

    // ----------------------------------------
    // Update enable
    // ----------------------------------------
    logic upd_tick;
    logic [3:0] upd_cnt_q;
    logic upd_q;

    assign upd_tick = ctrl_q[dsp_pkg::CTL_UPD_USER] ? user_tick : ref_tick;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upd_cnt_q <= '0;
            upd_q <= 1'b0;
        end else begin
            upd_q <= 1'b0;
            if (upd_tick) begin
                if (upd_cnt_q == dsp_pkg::UPD_TICKS - 4'h1) begin
                    upd_cnt_q <= '0;
                    upd_q <= 1'b1;
                end else begin
                    upd_cnt_q <= upd_cnt_q + 4'h1;
                end
            end
        end
    end
    assign upd_pulse = upd_q;

    // ----------------------------------------
    // Delay chain settings
    // ----------------------------------------
    logic [dsp_pkg::OFF_W-1:0] elem0_q;
    logic [dsp_pkg::SET_W-1:0] elem_q;
    logic [3:0] elem_en_q;
    logic bypass_q;
    logic [dsp_pkg::OFF_W-1:0] elem0_d;

    always_comb begin
        if (!ctrl_q[dsp_pkg::CTL_USE_OFF]) begin
            elem0_d = {1'b0, src_gray};
        end else if (ctrl_q[dsp_pkg::CTL_SIDE_LR]) begin
            elem0_d = adj_lr_gray;
        end else begin
            elem0_d = adj_tb_gray;
        end
    end

    // All elements change together, never between update pulses
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            elem0_q <= '0;
            elem_q <= '0;
            elem_en_q <= 4'hF;
            bypass_q <= 1'b0;
        end else if (upd_q) begin
            elem0_q <= elem0_d;
            elem_q <= src_gray;
            elem_en_q <= 4'hF >> (2'h3 - ctrl_q[dsp_pkg::CTL_CNT_LSB +: 2]);
            bypass_q <= ctrl_q[dsp_pkg::CTL_BYPASS];
        end
    end
    assign elem0_set = elem0_q;
    assign elem_set = elem_q;
    assign elem_en = elem_en_q;
    assign chain_bypass = bypass_q;

    // ----------------------------------------
    // Postamble gate
    // ----------------------------------------
    logic hr_tick_q;
    logic hr_q;
    logic stage_in;
    logic pa_q;
    logic gate_q;

    assign stage_in = ctrl_q[dsp_pkg::CTL_HALF_RATE] ? hr_q : strobe_en;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hr_tick_q <= 1'b0;
            hr_q <= 1'b0;
        end else begin
            hr_tick_q <= ~hr_tick_q;
            if (hr_tick_q && ctrl_q[dsp_pkg::CTL_HALF_RATE]) begin
                hr_q <= strobe_en;
            end
        end
    end

    // AND of stage and its input: rising waits a stage, falling acts at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pa_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            pa_q <= stage_in;
            gate_q <= pa_q & stage_in;
        end
    end
    assign strobe_gate = gate_q;

    // ----------------------------------------
    // Leveling taps
    // ----------------------------------------
    logic [dsp_pkg::TAP_W-1:0] phase_q;
    logic [dsp_pkg::NUM_GROUPS-1:0] wl_dqs_q;
    logic [dsp_pkg::NUM_GROUPS-1:0] wl_dq_q;
    logic [dsp_pkg::NUM_GROUPS-1:0] rs_q;
    logic [dsp_pkg::NUM_GROUPS-1:0] pa_clk_q;
    logic hr_rs_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
            wl_dqs_q <= '0;
            wl_dq_q <= '0;
            rs_q <= '0;
            pa_clk_q <= '0;
            hr_rs_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 3'h1;
            for (int g = 0; g < dsp_pkg::NUM_GROUPS; g++) begin
                wl_dqs_q[g] <= dsp_pkg::tap_hi(phase_q, wl_taps_q[g*4 +: 3]);
                wl_dq_q[g] <= dsp_pkg::tap_hi(phase_q,
                    wl_taps_q[g*4 +: 3] - dsp_pkg::TAP_90);
                rs_q[g] <= dsp_pkg::tap_hi(phase_q, rs_taps_q[g*4 +: 3]);
                pa_clk_q[g] <= dsp_pkg::tap_hi(phase_q, pa_taps_q[g*4 +: 3]);
            end
            if (dsp_pkg::tap_hi(phase_q, rs_taps_q[2:0]) && !rs_q[0]) begin
                hr_rs_q <= ~hr_rs_q;
            end
        end
    end
    assign wl_dqs_clk = wl_dqs_q;
    assign wl_dq_clk = wl_dq_q;
    assign rs_clk = rs_q;
    assign pa_clk = pa_clk_q;
    assign hr_rs_clk = hr_rs_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_upd_single: assert property (@(posedge mclk) disable iff (!rst_n)
        upd_q |=> !upd_q)
        else $error("update enable longer than one cycle");

    a_chain_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !upd_q |=> $stable(elem0_q) && $stable(elem_q) && $stable(elem_en_q))
        else $error("chain setting changed without update");

    a_elem_count: assert property (@(posedge mclk) disable iff (!rst_n)
        (upd_q && ctrl_q[dsp_pkg::CTL_CNT_LSB +: 2] == 2'h0) |=> elem_en_q == 4'h1)
        else $error("element count not applied");

    a_bypass_load: assert property (@(posedge mclk) disable iff (!rst_n)
        upd_q |=> bypass_q == $past(ctrl_q[dsp_pkg::CTL_BYPASS]))
        else $error("bypass not loaded on update");

    a_gate_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        !stage_in |=> !gate_q)
        else $error("gate not dropped at once");

    a_gate_rise: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(strobe_en) && !ctrl_q[dsp_pkg::CTL_HALF_RATE] |=> !gate_q)
        else $error("gate rose without stage delay");

    a_hr_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !hr_tick_q |=> $stable(hr_q))
        else $error("half-rate stage moved off its enable");

    a_msb_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_hi && $stable(mode_hi) |=> !dll_set_q[dsp_pkg::SET_W-1])
        else $error("setting MSB not zero in high modes");

    a_upd_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
        upd_q |=> !upd_q [*7])
        else $error("update pulses closer than the tick interval");

    a_apb_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (acc && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("ready not one-cycle after one wait state");

endmodule : dsp_strobe_top
`default_nettype wire

// ==== dsp_far_model.sv ====
// Far-side model: DLL delay source and memory controller offset drive.
// Assumes one mclk domain shared with the strobe block.
`timescale 1ns/1ps
`default_nettype none
module dsp_far_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [5:0] dll_bin,
    input wire logic [5:0] amt_bin,
    input wire logic add,
    output logic [5:0] dll_gray,
    output logic [5:0] offset_amt,
    output logic offset_addnsub,
    output logic ref_tick
);
    // ----------------------------------------
    // Reference ticks and Gray drive
    // ----------------------------------------
    // One mclk feeds every interface on this DLL, so all share one rate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_tick <= 1'b0;
        end else begin
            ref_tick <= 1'b1;
        end
    end
    assign dll_gray = dll_bin ^ (dll_bin >> 1);
    assign offset_amt = amt_bin ^ (amt_bin >> 1);
    assign offset_addnsub = add;
endmodule : dsp_far_model
`default_nettype wire

// ==== dqs_strobe_phase_and_leveling_tb.sv ====
// Bench for the strobe block: offsets, update pulse, chain, postamble, APB.
// Assumes the far-side model supplies DLL setting, offset drive and reference ticks.
`timescale 1ns/1ps
`default_nettype none
module dqs_strobe_phase_and_leveling_tb;
    typedef struct packed {
        logic [2:0] mode;
        logic dyn;
        logic [5:0] dll;
        logic [6:0] off;
        logic [6:0] exp;
    } dsp_row_t;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, add, strobe_en, e, bypass, tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] dll, amt, dgray, oamt, dset;
    logic [6:0] adj_lr;
    logic [3:0] elem_en;
    logic oadd, upd, gate;
    int err_count, n_tests, n, m;
    logic utick, hr_p;
    logic [5:0] udly;
    logic [3:0] wdqs_p, wdq_p, rs_p, pa_p;
    logic [3:0] wdqs [10], wdq [10], wrs [10], wpa [10];
    logic whr [10];
    localparam int LOCK_WAIT = 1280;
    // ----------------------------------------
    // Rows: static and dynamic offsets, clamps at both limits
    // ----------------------------------------
    dsp_row_t rows [8] = '{'{3'h0, 1'b0, 6'h1C, 7'h23, 7'h3F}, '{3'h0, 1'b0, 6'h1C, 7'h64, 7'h00},
        '{3'h4, 1'b0, 6'h1C, 7'h03, 7'h1F}, '{3'h4, 1'b0, 6'h1C, 7'h0A, 7'h20},
        '{3'h0, 1'b0, 6'h3C, 7'h0A, 7'h40}, '{3'h0, 1'b0, 6'h05, 7'h6C, 7'h00},
        '{3'h0, 1'b1, 6'h1C, 7'h7B, 7'h17}, '{3'h0, 1'b0, 6'h00, 7'h7F, 7'h00}};
    dsp_far_model far (.mclk(mclk), .rst_n(rst_n), .dll_bin(dll), .amt_bin(amt), .add(add),
        .dll_gray(dgray), .offset_amt(oamt), .offset_addnsub(oadd), .ref_tick(tick));
    dsp_strobe_top DUT (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dll_gray(dgray), .ref_tick(tick), .user_tick(utick),
        .offset_amt(oamt), .offset_addnsub(oadd), .user_delay_gray(udly),
        .strobe_en(strobe_en), .dll_set_gray(dset), .adj_tb_gray(), .adj_lr_gray(adj_lr),
        .sign_tb(), .sign_lr(), .upd_pulse(upd), .elem0_set(), .elem_set(),
        .elem_en(elem_en), .chain_bypass(bypass), .strobe_gate(gate), .wl_dqs_clk(wdqs_p),
        .wl_dq_clk(wdq_p), .rs_clk(rs_p), .pa_clk(pa_p), .hr_rs_clk(hr_p));
    function automatic logic [6:0] g7(input logic [6:0] b);
        return b ^ (b >> 1);
    endfunction : g7
    task automatic close_out();
        $display("Checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // Sole controller on the bank group; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            err_count++;
            close_out();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wp();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (upd !== 1'b1 && n < 40);
        if (upd !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask : wp
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, dll, amt, strobe_en, utick, udly} = '0;
        add = 1'b1;
        repeat (3) @(posedge mclk);
        chk("elem_en_rst", 32'hF, 32'(elem_en));
        rst_n <= 1'b1;
        apb(1'b0, dsp_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_rst", 32'h118, rd);
        foreach (rows[i]) begin
            dll <= rows[i].dll;
            amt <= rows[i].off[6] ? 6'(-rows[i].off) : rows[i].off[5:0];
            add <= ~rows[i].off[6];
            apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h118 | {22'h0, rows[i].dyn, 6'h0, rows[i].mode});
            apb(1'b1, dsp_pkg::ADDR_OFF_TB, {25'h0, g7(rows[i].off)});
            apb(1'b1, dsp_pkg::ADDR_OFF_LR, 32'h0);
            repeat (3) @(posedge mclk);
            apb(1'b0, dsp_pkg::ADDR_STATUS, 32'h0);
            chk("adj_tb", 32'(g7(rows[i].exp)), 32'(rd[6:0]));
            chk("sign_tb", 32'(rows[i].off[6]), 32'(rd[24]));
            chk("adj_lr", 32'(g7(rows[i].dyn ? rows[i].exp : {1'b0, rows[i].dll})), 32'(adj_lr));
        end
        // Mode 4 with a setting above 31: only five tracked bits pass
        dll <= 6'h28;
        apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h11C);
        repeat (3) @(posedge mclk);
        chk("dll_set", 32'h1C, 32'(dset));
        // ----------------------------------------
        // Chain: user setting, one element, bypass, pulse spacing
        // ----------------------------------------
        udly <= 6'h2A;
        apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h020);
        wp();
        @(negedge mclk);
        chk("elem_en_one", 32'h1, 32'(elem_en));
        chk("bypass", 32'h1, 32'(bypass));
        wp();
        chk("upd_gap", 32'(dsp_pkg::UPD_TICKS), 32'(n));
        apb(1'b0, dsp_pkg::ADDR_CHAIN, 32'h0);
        chk("elem_user", 32'h2A, 32'(rd[11:6]));
        // User tick source: no ticks, no pulses
        apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h518);
        repeat (2) @(posedge mclk);
        m = 0;
        repeat (16) begin
            @(negedge mclk);
            if (upd !== 1'b0) m++;
        end
        chk("upd_user_idle", 32'h0, 32'(m));
        @(posedge mclk);
        utick <= 1'b1;
        wp();
        wp();
        chk("upd_user", 32'(dsp_pkg::UPD_TICKS), 32'(n));
        utick <= 1'b0;
        // ----------------------------------------
        // Postamble gate, full rate then half rate
        // ----------------------------------------
        apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h118);
        repeat (LOCK_WAIT) @(posedge mclk);
        strobe_en <= 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        chk("gate_late", 32'h0, 32'(gate));
        @(negedge mclk);
        chk("gate_on", 32'h1, 32'(gate));
        @(posedge mclk);
        strobe_en <= 1'b0;
        @(negedge mclk);
        @(negedge mclk);
        chk("gate_off", 32'h0, 32'(gate));
        apb(1'b1, dsp_pkg::ADDR_CTRL, 32'h918);
        strobe_en <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("gate_half_on", 32'h1, 32'(gate));
        @(posedge mclk);
        strobe_en <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("gate_half_off", 32'h0, 32'(gate));
        // ----------------------------------------
        // Leveling: sweep write taps, then group 0 tap 0, group 1 tap 4
        // ----------------------------------------
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, dsp_pkg::ADDR_WL_TAPS, 32'(t));
            apb(1'b0, dsp_pkg::ADDR_WL_TAPS, 32'h0);
            chk("wl_sweep", 32'(t), rd);
        end
        apb(1'b1, dsp_pkg::ADDR_WL_TAPS, 32'h040);
        apb(1'b1, dsp_pkg::ADDR_PA_TAPS, 32'h006);
        repeat (2) @(posedge mclk);
        for (int k = 0; k < 10; k++) begin
            @(negedge mclk);
            wdqs[k] = wdqs_p;
            wdq[k] = wdq_p;
            wrs[k] = rs_p;
            wpa[k] = pa_p;
            whr[k] = hr_p;
        end
        n = 0;
        m = 0;
        for (int k = 0; k < 8; k++) begin
            if (wdqs[k][0] === 1'b1) n++;
            if (whr[k+1] !== whr[k]) m++;
            chk("wl_dq", 32'(wdqs[k+2][0]), 32'(wdq[k][0]));
            chk("wl_grp", 32'(!wdqs[k][0]), 32'(wdqs[k][1]));
            chk("rs_tap", 32'(wdqs[k][0]), 32'(wrs[k][0]));
            chk("pa_tap", 32'(wdq[k][0]), 32'(wpa[k][0]));
        end
        chk("wl_duty", 32'h4, 32'(n));
        chk("hr_rs", 32'h1, 32'(m));
        // ----------------------------------------
        // Mid-run reset, then an unmapped address
        // ----------------------------------------
        @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        chk("elem_en_rst2", 32'hF, 32'(elem_en));
        chk("gate_rst2", 32'h0, 32'(gate));
        @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, dsp_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_rst2", 32'(dsp_pkg::CTRL_RST), rd);
        apb(1'b1, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, 32'(e));
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_rd", 32'h0, rd);
        chk("unmapped_rerr", 32'h1, 32'(e));
        close_out();
    end
endmodule : dqs_strobe_phase_and_leveling_tb
`default_nettype wire
